// ==== hw/owm_pkg.sv ====
// Constants, types and the CRC helper shared by both ends of the memory link.
package owm_pkg;

    // ************************************************************
    // Command codes and answer bytes
    // ************************************************************
    localparam logic [7:0] CMD_READ_MEM = 8'hF0;
    localparam logic [7:0] CMD_PROTECT = 8'hC3;
    localparam logic [7:0] CMD_READ_PROT = 8'hAA;
    localparam logic [7:0] CS_SUCCESS = 8'hAA;
    localparam logic [7:0] CS_ALREADY = 8'h55;
    localparam logic [7:0] CS_PROG_FAIL = 8'hEE;
    localparam logic [7:0] STAT_OPEN = 8'h0F;
    localparam logic [7:0] STAT_LOCKED = 8'hF0;
    localparam logic [7:0] FILL_BYTE = 8'hFF;

    // ************************************************************
    // Memory geometry and parameter byte layout
    // ************************************************************
    localparam int BLOCKS = 31;
    localparam int BLOCK_BYTES = 8;
    localparam int MEM_BYTES = BLOCKS * BLOCK_BYTES;
    localparam int BN_MSB = 4;
    localparam logic [4:0] LAST_BLOCK = 5'h1E;
    localparam logic [2:0] LAST_BYTE = 3'h7;
    localparam logic [15:0] CRC_CLEAR = 16'h0000;
    localparam logic [15:0] CRC_POLY_REV = 16'hA001;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_US = 10;
    localparam int PROG_CYCLES = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam logic [9:0] PROG_LAST = 10'(PROG_CYCLES - 1);

    // ************************************************************
    // Master operation kinds and FIFO sizing
    // ************************************************************
    typedef enum logic [1:0] {
        OP_RESET = 2'h0,
        OP_WRITE = 2'h1,
        OP_READ = 2'h2
    } owm_op_t;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;

    // Shifts one byte into a CRC-16 generator, least significant bit first.
    function automatic logic [15:0] owm_crc16_byte(
        input logic [15:0] crc_in,
        input logic [7:0] data
    );
        logic [15:0] c;
        logic fb;
        c = crc_in;
        for (int i = 0; i < 8; i++)
        begin
            fb = c[0] ^ data[i];
            c = c >> 1;
            if (fb)
            begin
                c = c ^ CRC_POLY_REV;
            end
        end
        return c;
    endfunction

    // Flat byte index of a byte inside a block.
    function automatic logic [7:0] owm_mem_index(
        input logic [4:0] blk,
        input logic [2:0] idx
    );
        return {blk, idx};
    endfunction

endpackage

// ==== hw/owm_link_if.sv ====
// Byte-level link between the bus master end and the memory device end.
`timescale 1ns/1ps
interface owm_link_if;
    logic bus_reset;
    logic wr_valid;
    logic [7:0] wr_data;
    logic rd_req;
    logic rd_valid;
    logic [7:0] rd_data;

    modport dev (
        input bus_reset,
        input wr_valid,
        input wr_data,
        input rd_req,
        output rd_valid,
        output rd_data
    );

    modport mst (
        output bus_reset,
        output wr_valid,
        output wr_data,
        output rd_req,
        input rd_valid,
        input rd_data
    );
endinterface

// ==== hw/owm_fifo.sv ====
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module owm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = store[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write.
    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            store[wr_ptr] <= in_data;
        end
    end

    // Pointers and count.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
            end
            if (pop)
            begin
                rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // owm_fifo

// ==== hw/owm_device.sv ====
// Memory device end: command interpreter for read, protect and status.
// Contract
// - F0h then parameter byte starts read
// - Block number is parameter's five low bits
// - Only blocks 0 to 30 are valid
// - Parameter CRC covers command and parameter
// - Each block followed by its own CRC
// - Block CRC fed in transmit order
// - Further reads continue with next block
// - After last block CRC, send FFh
// - Bus reset abandons memory read
// - All three commands accepted any time; the code takes one only as the first byte after a reset
// - C3h sets a permanent protect flag
// - Master aborts protect on bad CRC
// - Release byte starts programming, then status
// - Status AAh, 55h already, EEh failure
// - AAh command sends 0Fh or F0h per block
// - Status continues per block, then FFh
// - Bus reset ends protection status read
// - Thirty-one blocks of eight bytes each
// - CRC inverted, everything LSB first
// - Parameter CRC only for valid parameter
`timescale 1ns/1ps
module owm_device
    import owm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    owm_link_if.dev link,
    input wire logic ld_valid,
    input wire logic [7:0] ld_addr,
    input wire logic [7:0] ld_data,
    input wire logic prog_fail,
    output logic [BLOCKS-1:0] prot_flags,
    output logic busy
);
    // ************************************************************
    // State and storage
    // ************************************************************
    typedef enum logic [10:0] {
        ST_CMD = 11'h001,
        ST_PARAM = 11'h002,
        ST_CRC = 11'h004,
        ST_DATA = 11'h008,
        ST_BCRC = 11'h010,
        ST_REL = 11'h020,
        ST_PROG = 11'h040,
        ST_CS = 11'h080,
        ST_STAT = 11'h100,
        ST_TAIL = 11'h200,
        ST_DEAD = 11'h400
    } owm_dev_state_t;

    owm_dev_state_t state;
    logic [7:0] mem [MEM_BYTES];
    logic [BLOCKS-1:0] prot;
    logic [7:0] cmd;
    logic [4:0] blk;
    logic [2:0] byte_idx;
    logic [15:0] crc;
    logic crc_hi;
    logic [9:0] prog_cnt;
    logic [7:0] cs_byte;
    logic rd_pend;
    logic rd_valid_q;
    logic [7:0] rd_data_q;
    logic answer;
    logic [7:0] ans_byte;
    logic [4:0] bn;

    assign link.rd_valid = rd_valid_q;
    assign link.rd_data = rd_data_q;
    assign prot_flags = prot;
    assign busy = (state == ST_PROG);
    // Only the five low bits name a block; the upper three are ignored.
    assign bn = link.wr_data[BN_MSB:0];
    // A pending read is answered in any state except while programming.
    assign answer = rd_pend && (state != ST_PROG) && !link.bus_reset;

    // ************************************************************
    // Answer byte selection
    // ************************************************************

    // Picks the byte that the next read slot returns in each state.
    always_comb
    begin
        ans_byte = FILL_BYTE;
        unique case (state)
            ST_CRC, ST_BCRC:
            begin
                // The CRC goes out inverted, low byte first.
                ans_byte = crc_hi ? ~crc[15:8] : ~crc[7:0];
            end
            ST_DATA:
            begin
                ans_byte = mem[owm_mem_index(blk, byte_idx)];
            end
            ST_CS:
            begin
                ans_byte = cs_byte;
            end
            ST_STAT:
            begin
                ans_byte = prot[blk] ? STAT_LOCKED : STAT_OPEN;
            end
            ST_CMD, ST_PARAM, ST_REL, ST_PROG, ST_TAIL, ST_DEAD:
            begin
                // Bus left released: a read slot sees all ones.
                ans_byte = FILL_BYTE;
            end
        endcase
    end

    // ************************************************************
    // Read slot handshake
    // ************************************************************

    // Holds a read request until the interpreter can answer it.
    always_ff @(posedge sys_clk)
    begin
        if (rst || link.bus_reset)
        begin
            rd_pend <= 1'b0;
        end
        else if (link.rd_req)
        begin
            rd_pend <= 1'b1;
        end
        else if (answer)
        begin
            rd_pend <= 1'b0;
        end
    end

    // Registers the answer byte and its one-cycle valid strobe.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q <= FILL_BYTE;
        end
        else
        begin
            rd_valid_q <= answer;
            if (answer)
            begin
                rd_data_q <= ans_byte;
            end
        end
    end

    // ************************************************************
    // User memory and protection flags
    // ************************************************************

    // Loads user memory from the user side, since writes are not carried.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < MEM_BYTES; i++)
            begin
                mem[i] <= 8'h00;
            end
        end
        else if (ld_valid && (ld_addr < 8'(MEM_BYTES)))
        begin
            mem[ld_addr] <= ld_data;
        end
    end

    // Protect flags only ever set; a bus reset leaves them alone.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            prot <= '0;
        end
        else if ((state == ST_PROG) && (prog_cnt == PROG_LAST)
                 && !prot[blk] && !prog_fail && !link.bus_reset)
        begin
            prot[blk] <= 1'b1;
        end
    end

    // ************************************************************
    // Command interpreter
    // ************************************************************

    // Walks command, parameter, CRC and the per-command data phase.
    always_ff @(posedge sys_clk)
    begin
        if (rst || link.bus_reset)
        begin
            state <= ST_CMD;
            cmd <= 8'h00;
            blk <= 5'h00;
            byte_idx <= 3'h0;
            crc <= CRC_CLEAR;
            crc_hi <= 1'b0;
            prog_cnt <= 10'h000;
            cs_byte <= FILL_BYTE;
        end
        else
        begin
            unique case (state)
                ST_CMD:
                begin
                    if (link.wr_valid)
                    begin
                        cmd <= link.wr_data;
                        crc <= owm_crc16_byte(CRC_CLEAR, link.wr_data);
                        if ((link.wr_data == CMD_READ_MEM)
                            || (link.wr_data == CMD_PROTECT)
                            || (link.wr_data == CMD_READ_PROT))
                        begin
                            state <= ST_PARAM;
                        end
                        else
                        begin
                            state <= ST_DEAD;
                        end
                    end
                end
                ST_PARAM:
                begin
                    if (link.wr_valid)
                    begin
                        blk <= bn;
                        crc <= owm_crc16_byte(crc, link.wr_data);
                        crc_hi <= 1'b0;
                        if (bn > LAST_BLOCK)
                        begin
                            state <= ST_DEAD;
                        end
                        else
                        begin
                            state <= ST_CRC;
                        end
                    end
                end
                ST_CRC:
                begin
                    if (answer)
                    begin
                        crc_hi <= 1'b1;
                        if (crc_hi)
                        begin
                            crc_hi <= 1'b0;
                            crc <= CRC_CLEAR;
                            byte_idx <= 3'h0;
                            if (cmd == CMD_READ_MEM)
                            begin
                                state <= ST_DATA;
                            end
                            else if (cmd == CMD_PROTECT)
                            begin
                                state <= ST_REL;
                            end
                            else
                            begin
                                state <= ST_STAT;
                            end
                        end
                    end
                end
                ST_DATA:
                begin
                    if (answer)
                    begin
                        // Feed each byte as it goes out.
                        crc <= owm_crc16_byte(crc, ans_byte);
                        byte_idx <= byte_idx + 3'h1;
                        if (byte_idx == LAST_BYTE)
                        begin
                            state <= ST_BCRC;
                        end
                    end
                end
                ST_BCRC:
                begin
                    if (answer)
                    begin
                        crc_hi <= !crc_hi;
                        if (crc_hi && (blk == LAST_BLOCK))
                        begin
                            state <= ST_TAIL;
                        end
                        else if (crc_hi)
                        begin
                            blk <= blk + 5'h01;
                            crc <= CRC_CLEAR;
                            state <= ST_DATA;
                        end
                    end
                end
                ST_REL:
                begin
                    if (link.wr_valid)
                    begin
                        prog_cnt <= 10'h000;
                        state <= ST_PROG;
                    end
                end
                ST_PROG:
                begin
                    prog_cnt <= prog_cnt + 10'h001;
                    if (prog_cnt == PROG_LAST)
                    begin
                        if (prot[blk])
                        begin
                            cs_byte <= CS_ALREADY;
                        end
                        else if (prog_fail)
                        begin
                            cs_byte <= CS_PROG_FAIL;
                        end
                        else
                        begin
                            cs_byte <= CS_SUCCESS;
                        end
                        state <= ST_CS;
                    end
                end
                ST_CS:
                begin
                    if (answer)
                    begin
                        state <= ST_TAIL;
                    end
                end
                ST_STAT:
                begin
                    if (answer)
                    begin
                        if (blk == LAST_BLOCK)
                        begin
                            state <= ST_TAIL;
                        end
                        else
                        begin
                            blk <= blk + 5'h01;
                        end
                    end
                end
                ST_TAIL, ST_DEAD:
                begin
                    state <= state;
                end
            endcase
        end
    end
endmodule // owm_device

// ==== hw/owm_master.sv ====
// Bus master end: runs user operations on the link, buffers read bytes.
`timescale 1ns/1ps
module owm_master
    import owm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    owm_link_if.mst link,
    input wire logic op_valid,
    output logic op_ready,
    input wire owm_op_t op_kind,
    input wire logic [7:0] op_data,
    output logic res_valid,
    input wire logic res_ready,
    output logic [7:0] res_data,
    output logic crc_abort
);
    typedef enum logic [1:0] {
        MS_IDLE = 2'h1,
        MS_WAIT = 2'h2
    } owm_mst_state_t;

    owm_mst_state_t mstate;
    logic bus_reset_q;
    logic wr_valid_q;
    logic [7:0] wr_data_q;
    logic rd_req_q;
    logic [1:0] wcnt;
    logic [1:0] rcnt;
    logic [7:0] cmd;
    logic [15:0] crc;
    logic fifo_in_ready;
    logic take;
    logic mismatch;

    assign link.bus_reset = bus_reset_q;
    assign link.wr_valid = wr_valid_q;
    assign link.wr_data = wr_data_q;
    assign link.rd_req = rd_req_q;
    // A read is only issued while the FIFO has room for its answer.
    assign op_ready = (mstate == MS_IDLE)
                      && ((op_kind != OP_READ) || fifo_in_ready);
    assign take = op_valid && op_ready;
    // Compares the returned protect CRC against the expected inverse.
    assign mismatch = link.rd_valid && (cmd == CMD_PROTECT)
                      && (wcnt == 2'h2) && (rcnt < 2'h2)
                      && (link.rd_data != (rcnt[0] ? ~crc[15:8] : ~crc[7:0]));

    // ************************************************************
    // Link drive
    // ************************************************************

    // Turns operations into one-cycle link strobes and waits for answers.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mstate <= MS_IDLE;
            bus_reset_q <= 1'b0;
            wr_valid_q <= 1'b0;
            wr_data_q <= 8'h00;
            rd_req_q <= 1'b0;
            crc_abort <= 1'b0;
        end
        else
        begin
            bus_reset_q <= 1'b0;
            wr_valid_q <= 1'b0;
            rd_req_q <= 1'b0;
            crc_abort <= 1'b0;
            if (mstate == MS_WAIT)
            begin
                if (link.rd_valid)
                begin
                    mstate <= MS_IDLE;
                    bus_reset_q <= mismatch;
                    crc_abort <= mismatch;
                end
            end
            else if (take)
            begin
                bus_reset_q <= (op_kind == OP_RESET);
                wr_valid_q <= (op_kind == OP_WRITE);
                wr_data_q <= op_data;
                rd_req_q <= (op_kind == OP_READ);
                if (op_kind == OP_READ)
                begin
                    mstate <= MS_WAIT;
                end
            end
        end
    end

    // Tracks the command, its CRC and byte counts since the last reset.
    always_ff @(posedge sys_clk)
    begin
        if (rst || (take && (op_kind == OP_RESET)) || bus_reset_q)
        begin
            wcnt <= 2'h0;
            rcnt <= 2'h0;
            cmd <= 8'h00;
            crc <= CRC_CLEAR;
        end
        else
        begin
            if (take && (op_kind == OP_WRITE) && (wcnt < 2'h2))
            begin
                wcnt <= wcnt + 2'h1;
                crc <= owm_crc16_byte(crc, op_data);
                if (wcnt == 2'h0)
                begin
                    cmd <= op_data;
                end
            end
            if (link.rd_valid && (rcnt < 2'h2))
            begin
                rcnt <= rcnt + 2'h1;
            end
        end
    end

    // ************************************************************
    // Read data buffer
    // ************************************************************

    // Every answered read byte is queued for the user.
    owm_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(link.rd_valid && (mstate == MS_WAIT)),
        .in_ready(fifo_in_ready),
        .in_data(link.rd_data),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );
endmodule // owm_master

// ==== tb/owm_link_monitor.sv ====
// Checker watching the byte link between the two ends.
`timescale 1ns/1ps
module owm_link_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bus_reset,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic rd_req,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data
);
    logic pend;
    logic [10:0] wait_cnt;
    // Longest wait: the 1000-cycle programming time plus 100 cycles.
    localparam logic [10:0] WAIT_LIMIT = 11'h44C;

    // Marks a read request that is still waiting for its byte.
    always_ff @(posedge sys_clk)
        if (rst || rd_valid)
            pend <= 1'b0;
        else if (rd_req)
            pend <= 1'b1;

    // Counts the cycles that the open request has been waiting.
    always_ff @(posedge sys_clk)
    begin
        if (rst || !pend)
        begin
            wait_cnt <= 11'h000;
        end
        else if (wait_cnt != 11'h7FF)
        begin
            wait_cnt <= wait_cnt + 11'h001;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Every request gets a byte, even across programming time.
    property p_answer;
        wait_cnt < WAIT_LIMIT;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_asked;
        rd_valid |-> pend;
    endproperty
    a_asked: assert property (p_asked) else $error("unasked byte");
    property p_pulse;
        rd_valid |=> !rd_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long strobe");
    property p_hold;
        !rd_valid |-> $stable(rd_data);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_dead;
        wr_valid && wr_data == 8'hF0 ##1 wr_valid && wr_data[4:0] == 5'h1F
            |=> (!rd_valid || rd_data == 8'hFF) [*8];
    endproperty
    a_dead: assert property (p_dead) else $error("bad block answered");
    property p_prompt;
        wr_valid && wr_data == 8'hF0 ##1 wr_valid && wr_data[4:0] != 5'h1F
            ##1 rd_req |-> ##2 rd_valid;
    endproperty
    a_prompt: assert property (p_prompt) else $error("slow check");
    property p_abort;
        bus_reset |=> !rd_valid;
    endproperty
    a_abort: assert property (p_abort) else $error("byte after abort");
    property p_gap;
        rd_req |-> !rd_valid;
    endproperty
    a_gap: assert property (p_gap) else $error("early byte");
endmodule // owm_link_monitor

// ==== tb/tb_onewire_mem_read_protect_cmds.sv ====
// Bench driving the master end against the device end.
`timescale 1ns/1ps
module tb_onewire_mem_read_protect_cmds
    import owm_pkg::*;
;
    logic sys_clk = 0, rst = 1, op_valid = 0, res_ready = 0;
    logic ld_valid = 0, prog_fail = 0, op_ready, res_valid, busy;
    owm_op_t op_kind = OP_RESET;
    logic [7:0] op_data = 8'h00, ld_addr = 8'h00, ld_data = 8'h00, res_data;
    logic [7:0] pat [8];
    logic [BLOCKS-1:0] prot_flags;
    int err_count = 0, num_checks = 0;
    owm_link_if u_owm_link_if ();
    owm_device u_owm_device (.sys_clk(sys_clk), .rst(rst),
        .link(u_owm_link_if.dev), .ld_valid(ld_valid), .ld_addr(ld_addr),
        .ld_data(ld_data), .prog_fail(prog_fail), .prot_flags(prot_flags),
        .busy(busy));
    owm_master u_owm_master (.sys_clk(sys_clk), .rst(rst),
        .link(u_owm_link_if.mst), .op_valid(op_valid), .op_ready(op_ready),
        .op_kind(op_kind), .op_data(op_data), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data), .crc_abort());
    owm_link_monitor u_owm_link_monitor (.sys_clk(sys_clk), .rst(rst),
        .bus_reset(u_owm_link_if.bus_reset), .wr_valid(u_owm_link_if.wr_valid),
        .wr_data(u_owm_link_if.wr_data), .rd_req(u_owm_link_if.rd_req),
        .rd_valid(u_owm_link_if.rd_valid), .rd_data(u_owm_link_if.rd_data));

    // Free-running system clock.
    initial
        forever #5 sys_clk = ~sys_clk;

    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [15:0] crc(logic [15:0] c, logic [7:0] d);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'hA001 : c >> 1;
        return c;
    endfunction
    // Offers one operation and leaves op_valid up once it is taken.
    task automatic op(owm_op_t k, logic [7:0] d);
        op_valid = 1;
        op_kind = k;
        op_data = d;
        while (op_ready !== 1'b1)
            @(negedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic cmd(logic [7:0] c, logic [7:0] p);
        op(OP_RESET, 8'h00);
        op(OP_WRITE, c);
        op(OP_WRITE, p);
    endtask
    task automatic pop(string nm, logic [7:0] exp);
        while (res_valid !== 1'b1)
            @(negedge sys_clk);
        chk(nm, exp, res_data);
        res_ready = 1;
        @(negedge sys_clk);
        res_ready = 0;
    endtask
    task automatic rd(string nm, logic [7:0] exp);
        op(OP_READ, 8'h00);
        op_valid = 0;
        pop(nm, exp);
    endtask
    task automatic rd_crc(logic [15:0] c);
        rd("crc_lo", ~c[7:0]);
        rd("crc_hi", ~c[15:8]);
    endtask
    task automatic t_read();
        logic [15:0] c;
        logic [7:0] d;
        cmd(CMD_READ_MEM, 8'h1F);
        rd("dead", FILL_BYTE);
        cmd(CMD_READ_MEM, 8'hFD);
        rd_crc(crc(crc(16'h0000, 8'hF0), 8'hFD));
        for (int b = 0; b < 2; b++)
        begin
            c = 16'h0000;
            for (int i = 0; i < 8; i++)
            begin
                d = b ? pat[i] : 8'h00;
                rd("data", d);
                c = crc(c, d);
            end
            rd_crc(c);
        end
        rd("tail", FILL_BYTE);
    endtask
    task automatic t_prot(logic [7:0] p, logic [7:0] cs);
        cmd(CMD_PROTECT, p);
        rd_crc(crc(crc(16'h0000, 8'hC3), p));
        op(OP_WRITE, 8'h00);
        op(OP_READ, 8'h00);
        op_valid = 0;
        chk("busy", 8'h01, {7'h00, busy});
        pop("cs", cs);
    endtask
    task automatic t_stat();
        logic [15:0] c;
        c = crc(crc(16'h0000, 8'hAA), 8'h01);
        cmd(CMD_READ_PROT, 8'h01);
        for (int i = 0; i < FIFO_DEPTH; i++)
            op(OP_READ, 8'h00);
        repeat (8) @(negedge sys_clk);
        chk("full", 8'h00, {7'h00, op_ready});
        op_valid = 0;
        pop("crc_lo", ~c[7:0]);
        pop("crc_hi", ~c[15:8]);
        for (int b = 1; b < 31; b++)
            pop("stat", b == 5 ? 8'hF0 : 8'h0F);
        rd("tail", FILL_BYTE);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence: reset, preload the last block, then the scenarios.
    initial
    begin
        repeat (20) @(negedge sys_clk);
        rst = 0;
        for (int i = 0; i < 8; i++)
        begin
            pat[i] = 8'h3C ^ 8'(i * 37);
            ld_valid = 1;
            ld_addr = 8'hF0 + 8'(i);
            ld_data = pat[i];
            @(negedge sys_clk);
        end
        ld_valid = 0;
        t_read();
        prog_fail = 1;
        t_prot(8'h00, CS_PROG_FAIL);
        prog_fail = 0;
        t_prot(8'hE5, CS_SUCCESS);
        t_prot(8'h05, CS_ALREADY);
        chk("flag", 8'h01, {7'h00, prot_flags[5]});
        t_stat();
        complete_run();
    end

    // Watchdog cutting a hung run short.
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end
endmodule // tb_onewire_mem_read_protect_cmds
